// ### dsw_axis_model.sv
// Behavioural axis model on the far side: moves while a mode runs, reports standstill and completion
`timescale 1ns/1ps
module dsw_axis_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mode_run,
  input wire logic halt_req,
  input wire logic quick_stop,
  input wire logic fault_active,
  input wire logic [7:0] move_cycles,
  output logic standstill,
  output logic mode_done_ok
);
  logic run_q;
  logic done_q;
  logic [7:0] cnt_q;
  // Any stop request brings the axis to rest without success
  wire logic stop_now = halt_req | quick_stop | fault_active;
  // A queued mode shows as mode_run held high just after a completion pulse
  wire logic begin_move = standstill && mode_run && (!run_q || done_q) && !stop_now;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      standstill <= 1'b1;
      mode_done_ok <= 1'b0;
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      run_q <= mode_run;
      done_q <= mode_done_ok;
      mode_done_ok <= 1'b0;
      if (begin_move) begin
        standstill <= 1'b0;
        cnt_q <= move_cycles;
      end else if (!standstill && (stop_now || cnt_q == 8'h00)) begin
        standstill <= 1'b1;
        mode_done_ok <= !stop_now;
      end else if (!standstill) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule // dsw_axis_model

// ### dsw_pkg.sv
// Package for the drive status word block: register map, field layout, mode codes and timing
package dsw_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_CONTROL = 5'h04;
  localparam logic [4:0] ADDR_OPMODE = 5'h08;
  localparam logic [4:0] ADDR_ACT_OPMODE = 5'h0c;
  localparam logic [4:0] ADDR_LOCAL_DEF = 5'h10;

  // Control word field positions
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_FAULT_RST_BIT = 7;

  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] OPMODE_RST = 16'h0000;
  localparam logic [15:0] LOCAL_DEF_RST = 16'h0003;

  // Operating mode codes; profile position and homing are started by the control word start bit
  localparam logic [15:0] MODE_PROFILE_POS = 16'h0001;
  localparam logic [15:0] MODE_HOMING = 16'h0006;
  localparam logic [15:0] MODE_NONE = 16'h0000;

  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned WARN_HOLD_MS = 100;
  localparam int unsigned WARN_HOLD_CYC = (CLK_HZ / 1000) * WARN_HOLD_MS;
  localparam int WARN_CNT_W = 21;

  // Drive-side inputs
  typedef struct packed {
    logic [1:0] sm_hi;
    logic [3:0] sm_lo;
    logic dc_bus_ok;
    logic halt_req;
    logic quick_stop;
    logic fault_active;
    logic standstill;
    logic mode_done_ok;
    logic mode_monitor;
    logic ref_valid;
    logic ready_to_start;
    logic initialised;
    logic local_mode;
    logic enable_in;
  } dsw_drv_s;

  // Status word, bit 15 first
  typedef struct packed {
    logic ref_ok;
    logic x_end;
    logic x_err;
    logic mode_mon;
    logic rsvd;
    logic target;
    logic remote;
    logic halt;
    logic warn;
    logic [1:0] sm_hi;
    logic volt_en;
    logic [3:0] sm_lo;
  } dsw_status_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b10
  } dsw_seq_e;

endpackage

// ### dsw_status_word.sv
// Drive status word upper bits and operating mode start and change sequencer
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module dsw_status_word #(
  parameter int unsigned WARN_HOLD_CYC = dsw_pkg::WARN_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire dsw_pkg::dsw_drv_s drv,
  input wire logic [15:0] pending_warning_list,
  output dsw_pkg::dsw_status_s drive_status_word,
  output logic sm_3to4_allow,
  output logic motor_energise,
  output logic mode_run,
  output logic [15:0] active_op_mode,
  output logic fault_reset
);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic start_bit_mode(input logic [15:0] m);
    start_bit_mode = (m == dsw_pkg::MODE_PROFILE_POS) || (m == dsw_pkg::MODE_HOMING);
  endfunction

  // Bus slave: one wait state so read data come from a flop
  logic ack_q;
  logic [31:0] rdata_q;
  wire bus_req = avs_read | avs_write;
  wire wr_en = avs_write & ack_q;
  wire wr_ctrl = wr_en & (avs_address == dsw_pkg::ADDR_CONTROL);
  wire wr_opm = wr_en & (avs_address == dsw_pkg::ADDR_OPMODE);
  wire wr_ldef = wr_en & (avs_address == dsw_pkg::ADDR_LOCAL_DEF);

  assign avs_waitrequest = bus_req & ~ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Software registers
  logic [15:0] ctrl_q;
  logic [15:0] req_mode_q;
  logic [15:0] local_def_q;
  logic [15:0] act_mode_q;
  dsw_pkg::dsw_status_s status_q;
  dsw_pkg::dsw_seq_e st_q;
  dsw_pkg::dsw_seq_e st_d;

  wire [15:0] ctrl_wv = merge16(ctrl_q, avs_writedata, avs_byteenable);
  wire [15:0] opm_wv = merge16(req_mode_q, avs_writedata, avs_byteenable);
  wire [15:0] ldef_wv = merge16(local_def_q, avs_writedata, avs_byteenable);

  logic [31:0] rd_mux;
  always_comb begin
    unique case (avs_address)
      dsw_pkg::ADDR_STATUS: rd_mux = {16'h0000, status_q};
      dsw_pkg::ADDR_CONTROL: rd_mux = {16'h0000, ctrl_q};
      dsw_pkg::ADDR_OPMODE: rd_mux = {16'h0000, req_mode_q};
      dsw_pkg::ADDR_ACT_OPMODE: rd_mux = {16'h0000, act_mode_q};
      dsw_pkg::ADDR_LOCAL_DEF: rd_mux = {16'h0000, local_def_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Fault reset is a write of control bit 7; start is a rising control bit 4
  wire fault_reset_w = wr_ctrl & ctrl_wv[dsw_pkg::CTRL_FAULT_RST_BIT];
  wire ctrl_start_rise = wr_ctrl & ctrl_wv[dsw_pkg::CTRL_START_BIT] & ~ctrl_q[dsw_pkg::CTRL_START_BIT];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= dsw_pkg::CONTROL_RST;
      req_mode_q <= dsw_pkg::OPMODE_RST;
      local_def_q <= dsw_pkg::LOCAL_DEF_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wv;
      end
      if (wr_opm) begin
        req_mode_q <= opm_wv;
      end
      // Default mode may only change while nothing runs
      if (wr_ldef && st_q != dsw_pkg::ST_RUN) begin
        local_def_q <= ldef_wv;
      end
    end
  end

  // Start requests
  logic en_q;
  logic local_arm_q;
  wire local_rise = drv.local_mode & drv.enable_in & ~en_q;
  wire fb_start_opm = ~drv.local_mode & wr_opm & ~start_bit_mode(opm_wv);
  wire fb_start_bit = ~drv.local_mode & ctrl_start_rise & start_bit_mode(req_mode_q);
  wire local_start = drv.local_mode & drv.enable_in & local_arm_q;
  wire start_req = fb_start_opm | fb_start_bit | local_start;
  wire [15:0] start_mode = drv.local_mode ? local_def_q : (wr_opm ? opm_wv : req_mode_q);
  wire ready_ok = drv.ready_to_start & drv.initialised;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_q <= 1'b0;
      local_arm_q <= 1'b0;
      motor_energise <= 1'b0;
    end else begin
      en_q <= drv.enable_in;
      motor_energise <= drv.local_mode & drv.enable_in;
      if (!drv.enable_in || !drv.local_mode || st_q == dsw_pkg::ST_RUN) begin
        local_arm_q <= 1'b0;
      end else if (local_rise) begin
        local_arm_q <= 1'b1;
      end
    end
  end

  // Mode sequencer
  logic chain_q;
  logic chain_d;
  logic [15:0] chain_mode_q;
  logic [15:0] chain_mode_d;
  logic [15:0] act_mode_d;
  logic x_end_q;
  logic x_end_d;
  logic target_q;
  logic target_d;

  wire stop_cause = drv.mode_done_ok | drv.halt_req | drv.quick_stop;
  wire complete_w = (st_q == dsw_pkg::ST_RUN) & drv.standstill & stop_cause;
  wire go_w = (st_q == dsw_pkg::ST_IDLE) & start_req & ready_ok & ~drv.fault_active;
  wire chain_go = complete_w & chain_q & ready_ok & ~drv.fault_active;

  always_comb begin
    st_d = st_q;
    chain_d = chain_q;
    chain_mode_d = chain_mode_q;
    act_mode_d = act_mode_q;
    x_end_d = x_end_q;
    target_d = target_q;
    unique case (st_q)
      dsw_pkg::ST_IDLE: begin
        if (drv.fault_active) begin
          st_d = dsw_pkg::ST_FAULT;
        end else if (go_w) begin
          st_d = dsw_pkg::ST_RUN;
          act_mode_d = start_mode;
          x_end_d = 1'b0;
          target_d = 1'b0;
        end
      end
      dsw_pkg::ST_RUN: begin
        // Warnings are not looked at here, so they never stop a mode
        if (drv.fault_active) begin
          st_d = dsw_pkg::ST_FAULT;
          chain_d = 1'b0;
          target_d = 1'b0;
        end else if (complete_w) begin
          chain_d = 1'b0;
          target_d = drv.mode_done_ok & ~drv.halt_req & ~drv.quick_stop;
          if (chain_go) begin
            act_mode_d = chain_mode_q;
            target_d = 1'b0;
          end else begin
            st_d = dsw_pkg::ST_IDLE;
            x_end_d = 1'b1;
          end
        end else begin
          // A change to another mode waits for completion
          if (start_req && start_mode != act_mode_q) begin
            chain_d = 1'b1;
            chain_mode_d = start_mode;
          end
          target_d = 1'b0;
        end
      end
      dsw_pkg::ST_FAULT: begin
        if (drv.standstill) begin
          x_end_d = 1'b1;
        end
        if (!drv.fault_active) begin
          st_d = dsw_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = dsw_pkg::ST_IDLE;
      end
    endcase
    if (!drv.standstill) begin
      target_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= dsw_pkg::ST_IDLE;
      chain_q <= 1'b0;
      chain_mode_q <= dsw_pkg::MODE_NONE;
      act_mode_q <= dsw_pkg::MODE_NONE;
      x_end_q <= 1'b1;
      target_q <= 1'b0;
    end else begin
      st_q <= st_d;
      chain_q <= chain_d;
      chain_mode_q <= chain_mode_d;
      act_mode_q <= act_mode_d;
      x_end_q <= x_end_d;
      target_q <= target_d;
    end
  end

  // Warning with minimum hold; the clear by fault reset wins over a pending warning
  logic warn_q;
  logic warn_d;
  logic [dsw_pkg::WARN_CNT_W-1:0] warn_cnt_q;
  logic [dsw_pkg::WARN_CNT_W-1:0] warn_cnt_d;
  wire warn_pending = |pending_warning_list;
  wire warn_cnt_live = warn_cnt_q != '0;

  always_comb begin
    warn_cnt_d = warn_cnt_q;
    warn_d = warn_pending | warn_cnt_live;
    if (fault_reset_w) begin
      warn_cnt_d = '0;
      warn_d = 1'b0;
    end else if (warn_pending && !warn_q) begin
      warn_cnt_d = dsw_pkg::WARN_CNT_W'(WARN_HOLD_CYC - 1);
    end else if (warn_cnt_live) begin
      warn_cnt_d = warn_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      warn_q <= 1'b0;
      warn_cnt_q <= '0;
    end else begin
      warn_q <= warn_d;
      warn_cnt_q <= warn_cnt_d;
    end
  end

  // Status word assembly; internal bits use their next values so all fields line up
  dsw_pkg::dsw_status_s status_d;
  always_comb begin
    status_d.ref_ok = drv.ref_valid;
    status_d.x_end = x_end_d;
    status_d.x_err = drv.fault_active;
    status_d.mode_mon = drv.mode_monitor;
    status_d.rsvd = 1'b0;
    status_d.target = target_d;
    status_d.remote = ~drv.local_mode;
    status_d.halt = drv.halt_req;
    status_d.warn = warn_d;
    status_d.sm_hi = drv.sm_hi;
    status_d.volt_en = drv.dc_bus_ok;
    status_d.sm_lo = drv.sm_lo;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q <= '0;
      mode_run <= 1'b0;
      fault_reset <= 1'b0;
    end else begin
      status_q <= status_d;
      mode_run <= st_d == dsw_pkg::ST_RUN;
      fault_reset <= fault_reset_w;
    end
  end

  assign drive_status_word = status_q;
  assign active_op_mode = act_mode_q;
  assign sm_3to4_allow = drv.dc_bus_ok;

  // Helper: length of the current warning pulse
  logic [dsw_pkg::WARN_CNT_W-1:0] warn_len_q;
  always_ff @(posedge core_clk) begin
    if (rst || !warn_q) begin
      warn_len_q <= '0;
    end else if (warn_len_q != '1) begin
      warn_len_q <= warn_len_q + 1'b1;
    end
  end
  logic fr_seen_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fr_seen_q <= 1'b0;
    end else begin
      fr_seen_q <= fault_reset_w;
    end
  end

  a_volt_bit: assert property (@(posedge core_clk) disable iff (rst)
    drv.dc_bus_ok != $past(drv.dc_bus_ok) |=> drive_status_word.volt_en == $past(drv.dc_bus_ok))
    else $error("voltage bit does not follow bus");
  a_block_3to4: assert property (@(posedge core_clk) disable iff (rst)
    !drv.dc_bus_ok |-> !sm_3to4_allow)
    else $error("3 to 4 allowed without bus voltage");
  a_warn_follow: assert property (@(posedge core_clk) disable iff (rst)
    warn_pending && !fault_reset_w |=> drive_status_word.warn)
    else $error("warning bit missing");
  a_warn_no_stop: assert property (@(posedge core_clk) disable iff (rst)
    warn_pending && mode_run && !drv.fault_active && !complete_w |=> mode_run)
    else $error("warning stopped the running mode");
  a_warn_hold_min: assert property (@(posedge core_clk) disable iff (rst)
    $fell(warn_q) && !fr_seen_q |-> $past(warn_len_q) >= WARN_HOLD_CYC - 1)
    else $error("warning bit dropped before hold time");
  a_warn_reset_clear: assert property (@(posedge core_clk) disable iff (rst)
    fault_reset_w |=> !drive_status_word.warn ##1 (drive_status_word.warn == $past(warn_pending)))
    else $error("fault reset did not clear warning");
  a_halt_bit: assert property (@(posedge core_clk) disable iff (rst)
    drv.halt_req |=> drive_status_word.halt)
    else $error("halt bit missing");
  a_remote_bit: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> drive_status_word.remote != $past(drv.local_mode))
    else $error("remote bit wrong");
  a_target_moving: assert property (@(posedge core_clk) disable iff (rst)
    !drv.standstill || (complete_w && drv.halt_req) |=> !drive_status_word.target)
    else $error("target reached while moving or halted");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (rst)
    !drive_status_word.rsvd && (drive_status_word.mode_mon == $past(drv.mode_monitor)))
    else $error("reserved or monitor bit wrong");
  a_err_bit: assert property (@(posedge core_clk) disable iff (rst)
    drv.fault_active |=> drive_status_word.x_err && st_q == dsw_pkg::ST_FAULT)
    else $error("error bit or fault state missing");
  a_end_on_start: assert property (@(posedge core_clk) disable iff (rst)
    go_w |=> !drive_status_word.x_end && mode_run && active_op_mode == $past(start_mode))
    else $error("start did not clear process end");
  a_chain_no_end: assert property (@(posedge core_clk) disable iff (rst)
    chain_go |=> !drive_status_word.x_end && active_op_mode == $past(chain_mode_q))
    else $error("process end rose between chained modes");
  a_one_mode: assert property (@(posedge core_clk) disable iff (rst)
    st_q == dsw_pkg::ST_RUN && !complete_w |=> $stable(active_op_mode))
    else $error("mode changed while running");
  a_refuse_start: assert property (@(posedge core_clk) disable iff (rst)
    st_q == dsw_pkg::ST_IDLE && !ready_ok |=> st_q != dsw_pkg::ST_RUN)
    else $error("mode started while not ready");
  a_fault_resume: assert property (@(posedge core_clk) disable iff (rst)
    st_q == dsw_pkg::ST_FAULT && !drv.fault_active |=> st_q == dsw_pkg::ST_IDLE)
    else $error("no return to idle after fault");

  c_start_complete: cover property (@(posedge core_clk) disable iff (rst) go_w ##[1:20] complete_w);
  c_chain: cover property (@(posedge core_clk) disable iff (rst) chain_go);
  c_warn_reset: cover property (@(posedge core_clk) disable iff (rst) warn_q && fault_reset_w);
  c_local_start: cover property (@(posedge core_clk) disable iff (rst) go_w && drv.local_mode);

endmodule // dsw_status_word

// ### dsw_status_word_bench.sv
// Self-checking bench for the drive status word block
`timescale 1ns/1ps
module dsw_status_word_bench;
  // Short warning hold keeps the run brief
  localparam int HOLD = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dsw_pkg::dsw_drv_s drv_b = '0;
  dsw_pkg::dsw_drv_s drv;
  logic [15:0] pending_warning_list = 16'h0;
  dsw_pkg::dsw_status_s sw;
  logic sm_3to4_allow, motor_energise, mode_run, fault_reset, ax_still, ax_done;
  logic [15:0] active_op_mode;
  logic [7:0] move_cycles = 8'h04;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 32'hae3c;
  int k;
  int xe;
  logic [31:0] rnd;
  logic [31:0] rd;
  logic [4:0] ra [6] = '{dsw_pkg::ADDR_STATUS, dsw_pkg::ADDR_CONTROL, dsw_pkg::ADDR_OPMODE,
    dsw_pkg::ADDR_ACT_OPMODE, dsw_pkg::ADDR_LOCAL_DEF, 5'h14};
  // Remote bit is set out of reset because the fieldbus is the command source
  logic [31:0] re [6] = '{32'h4200, {16'h0, dsw_pkg::CONTROL_RST}, {16'h0, dsw_pkg::OPMODE_RST}, 32'h0,
    {16'h0, dsw_pkg::LOCAL_DEF_RST}, 32'h0};
  logic [15:0] sm [2] = '{dsw_pkg::MODE_PROFILE_POS, dsw_pkg::MODE_HOMING};

  dsw_status_word #(.WARN_HOLD_CYC(HOLD)) i_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .drv(drv),
    .pending_warning_list(pending_warning_list), .drive_status_word(sw), .sm_3to4_allow(sm_3to4_allow),
    .motor_energise(motor_energise), .mode_run(mode_run), .active_op_mode(active_op_mode),
    .fault_reset(fault_reset));
  dsw_axis_model i_axis (.core_clk(core_clk), .rst(rst), .mode_run(mode_run), .halt_req(drv_b.halt_req),
    .quick_stop(drv_b.quick_stop), .fault_active(drv_b.fault_active), .move_cycles(move_cycles),
    .standstill(ax_still), .mode_done_ok(ax_done));

  always_comb begin
    drv = drv_b;
    drv.standstill = ax_still;
    drv.mode_done_ok = ax_done;
  end

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon transfer; the answer latency is never assumed
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_run(input logic v);
    int n = 0;
    while (mode_run !== v && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk("mode_run", mode_run, v);
  endtask

  task automatic no_start();
    repeat (3) @(negedge core_clk);
    chk("mode_run idle", mode_run, 1'b0);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b1, dsw_pkg::ADDR_STATUS, 16'hffff);
    bus(1'b1, 5'h14, 16'hffff);
    for (k = 0; k < 6; k++) begin
      bus(1'b0, ra[k], 16'h0);
      chk("register read", rd, re[k]);
    end
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      rnd = $random(seed);
      drv_b.sm_hi <= rnd[1:0];
      drv_b.sm_lo <= rnd[5:2];
      drv_b.dc_bus_ok <= rnd[6];
      drv_b.halt_req <= rnd[7];
      drv_b.mode_monitor <= rnd[8];
      drv_b.ref_valid <= rnd[9];
      drv_b.local_mode <= rnd[10];
      @(posedge core_clk);
      @(negedge core_clk);
      chk("volt_en", sw.volt_en, rnd[6]);
      chk("allow 3to4", sm_3to4_allow, rnd[6]);
      chk("halt", sw.halt, rnd[7]);
      chk("remote", sw.remote, !rnd[10]);
      chk("mode_mon", sw.mode_mon, rnd[8]);
      chk("reserved", sw.rsvd, 1'b0);
      chk("ref_ok", sw.ref_ok, rnd[9]);
      chk("state bits", {sw.sm_hi, sw.sm_lo}, {rnd[1:0], rnd[5:2]});
    end
    @(posedge core_clk);
    drv_b <= '0;
    pending_warning_list <= rnd[15:0] | 16'h0001;
    @(posedge core_clk);
    pending_warning_list <= 16'h0;
    repeat (HOLD - 3) @(posedge core_clk);
    @(negedge core_clk);
    chk("warn held", sw.warn, 1'b1);
    repeat (6) @(negedge core_clk);
    chk("warn released", sw.warn, 1'b0);
    @(posedge core_clk);
    pending_warning_list <= 16'h8000;
    @(posedge core_clk);
    pending_warning_list <= 16'h0;
    bus(1'b1, dsw_pkg::ADDR_CONTROL, 16'h0080);
    @(negedge core_clk);
    chk("fault_reset", fault_reset, 1'b1);
    @(negedge core_clk);
    chk("warn cleared", sw.warn, 1'b0);
    bus(1'b1, dsw_pkg::ADDR_CONTROL, 16'h0000);
    drv_b.dc_bus_ok <= 1'b1;
    drv_b.initialised <= 1'b1;
    move_cycles <= 8'd30;
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0003);
    no_start();
    @(posedge core_clk);
    drv_b.ready_to_start <= 1'b1;
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0003);
    wait_run(1'b1);
    chk("x_end start", sw.x_end, 1'b0);
    chk("target running", sw.target, 1'b0);
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0005);
    @(negedge core_clk);
    chk("active held", active_op_mode, 16'h0003);
    xe = 0;
    for (k = 0; k < 200 && active_op_mode !== 16'h0005; k++) begin
      @(negedge core_clk);
      xe += int'(sw.x_end === 1'b1);
    end
    chk("x_end rises on change", xe, 0);
    chk("queued mode", active_op_mode, 16'h0005);
    wait_run(1'b0);
    chk("x_end done", sw.x_end, 1'b1);
    chk("target done", sw.target, 1'b1);
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0003);
    wait_run(1'b1);
    @(posedge core_clk);
    drv_b.halt_req <= 1'b1;
    wait_run(1'b0);
    chk("x_end halt", sw.x_end, 1'b1);
    chk("target halt", sw.target, 1'b0);
    @(posedge core_clk);
    drv_b.halt_req <= 1'b0;
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0003);
    wait_run(1'b1);
    @(posedge core_clk);
    drv_b.quick_stop <= 1'b1;
    wait_run(1'b0);
    chk("x_end quick stop", sw.x_end, 1'b1);
    chk("target quick stop", sw.target, 1'b0);
    @(posedge core_clk);
    drv_b.quick_stop <= 1'b0;
    for (k = 0; k < 2; k++) begin
      rnd = $random(seed);
      move_cycles <= 8'h02 + {4'h0, rnd[3:0]};
      bus(1'b1, dsw_pkg::ADDR_OPMODE, sm[k]);
      no_start();
      bus(1'b1, dsw_pkg::ADDR_CONTROL, 16'h0010);
      wait_run(1'b1);
      chk("active start bit", active_op_mode, sm[k]);
      wait_run(1'b0);
      bus(1'b1, dsw_pkg::ADDR_CONTROL, 16'h0000);
    end
    move_cycles <= 8'd30;
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0003);
    wait_run(1'b1);
    @(posedge core_clk);
    drv_b.fault_active <= 1'b1;
    wait_run(1'b0);
    chk("x_err fault", sw.x_err, 1'b1);
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0005);
    no_start();
    @(posedge core_clk);
    drv_b.fault_active <= 1'b0;
    bus(1'b1, dsw_pkg::ADDR_OPMODE, 16'h0005);
    wait_run(1'b1);
    chk("x_err clear", sw.x_err, 1'b0);
    wait_run(1'b0);
    @(posedge core_clk);
    drv_b.local_mode <= 1'b1;
    drv_b.enable_in <= 1'b1;
    wait_run(1'b1);
    chk("energise", motor_energise, 1'b1);
    chk("local default", active_op_mode, dsw_pkg::LOCAL_DEF_RST);
    @(posedge core_clk);
    pending_warning_list <= 16'h0040;
    repeat (3) @(negedge core_clk);
    chk("warn pending", sw.warn, 1'b1);
    chk("run kept", mode_run, 1'b1);
    wait_run(1'b0);
    end_of_test();
  end
endmodule // dsw_status_word_bench
